// [design/psm_pkg.sv]
// Shared constants, types and carriers of the power sequence monitor control block.
// Assumes a single 20 MHz master clock; analog parts (comparators, ADC, DACs) sit outside.
package psm_pkg;

	localparam int N_CH   = 12;
	localparam int N_IN   = 6;
	localparam int N_OUT  = 20;
	localparam int N_HV   = 4;
	localparam int N_DAC  = 8;
	localparam int N_TMR  = 4;
	localparam int N_PROF = 4;
	localparam int DAC_W  = 8;
	localparam int ADC_W  = 10;
	localparam int TMR_W  = 16;
	localparam int GRP_W  = 5;
	localparam int GRP_CH = 3;

	// Timing
	localparam int CLK_HZ     = 20_000_000;
	localparam int TICK_US    = 32;
	localparam int MAX_TIME_S = 2;
	localparam int TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [9:0]       TICK_LAST = 10'(TICK_CYC - 1);
	localparam logic [TMR_W-1:0] TMR_MAX   = TMR_W'(MAX_TIME_S * 1_000_000 / TICK_US);
	localparam logic [TMR_W-1:0] TMR_MIN   = 16'h0001;

	// Synchroniser vector layout
	localparam int SY_LO = 0;
	localparam int SY_HI = 12;
	localparam int SY_IN = 24;
	localparam int SY_PS = 30;
	localparam int SY_W  = 32;

	// Host write targets
	localparam logic [1:0] TGT_INPUTS  = 2'h0;
	localparam logic [1:0] TGT_OUT_VAL = 2'h1;
	localparam logic [1:0] TGT_OUT_EN  = 2'h2;
	localparam logic [1:0] TGT_DAC     = 2'h3;

	localparam logic [DAC_W-1:0] DAC_TOP = 8'hFF;
	localparam logic [DAC_W-1:0] DAC_BOT = 8'h00;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h1,
		S_RAMP  = 4'h2,
		S_RUN   = 4'h4,
		S_FAULT = 4'h8
	} seq_state_t;

	typedef struct packed {
		logic       wr;
		logic [1:0] tgt;
		logic [2:0] idx;
		logic [19:0] data;
	} host_cmd_t;

	typedef struct packed {
		logic             valid;
		logic [3:0]       ch;
		logic [ADC_W-1:0] data;
	} adc_sample_t;

	typedef struct packed {
		logic [N_DAC-1:0]            src_host;
		logic [N_DAC-1:0]            closed_loop;
		logic [N_DAC-1:0][ADC_W-1:0] target;
	} dac_cfg_t;

	typedef logic [N_TMR-1:0][TMR_W-1:0]             timer_load_t;
	typedef logic [N_PROF-1:0][N_DAC-1:0][DAC_W-1:0] preset_t;
	typedef logic [N_DAC-1:0][DAC_W-1:0]             dac_codes_t;

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             run;
		logic             done;
	} timer_state_t;

	typedef struct packed {
		logic [SY_W-1:0]  s1;
		logic [SY_W-1:0]  s2;
		logic [SY_W-1:0]  s3;
		logic [SY_W-1:0]  f;
		logic [9:0]       tdiv;
		logic             tick;
		logic [3:0]       in_ov_en;
		logic [3:0]       in_ov_val;
		logic [N_OUT-1:0] out_ov_en;
		logic [N_OUT-1:0] out_ov_val;
		dac_codes_t       host_dac;
		dac_codes_t       trim;
		logic [N_IN-1:0]  in_eff;
		logic [N_CH-1:0]  chan_ok;
		logic [N_TMR-1:0] grp;
		logic [N_OUT-1:0] seq_out;
		logic [N_OUT-1:0] oe_n;
		logic [N_HV-1:0]  hv;
		logic [1:0]       prof;
		logic [ADC_W-1:0] adc;
		logic [3:0]       adc_ch;
		seq_state_t       st;
		logic [1:0]       stage;
		logic [N_TMR-1:0] tstart;
	} main_state_t;

	localparam timer_state_t TIMER_RST = '{default: '0};
	localparam main_state_t  MAIN_RST  = '{st: S_IDLE, default: '0};

endpackage

// [design/psm_timer.sv]
// One sequencing timer counting 32 us ticks from a loaded interval.
// Assumes a one-cycle tick pulse from the parent on the same clock.
`timescale 1ns/1ns
`default_nettype none

module psm_timer (
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    ce_in,
	input  wire logic                    tick_in,
	input  wire logic                    start_in,
	input  wire logic [psm_pkg::TMR_W-1:0] load_in,
	output logic                         done_out
);

	psm_pkg::timer_state_t q;
	psm_pkg::timer_state_t d;

	always_comb begin
		d = q;
		if (start_in) begin
			// Interval clamped to the 32 us .. 2 s range
			if (load_in < psm_pkg::TMR_MIN) begin
				d.cnt = psm_pkg::TMR_MIN;
			end else if (load_in > psm_pkg::TMR_MAX) begin
				d.cnt = psm_pkg::TMR_MAX;
			end else begin
				d.cnt = load_in;
			end
			d.run  = 1'b1;
			d.done = 1'b0;
		end else if (q.run && tick_in) begin
			if (q.cnt == psm_pkg::TMR_MIN) begin
				d.cnt  = '0;
				d.run  = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - psm_pkg::TMR_MIN;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= psm_pkg::TIMER_RST;
		end else if (ce_in) begin
			q <= d;
		end
	end

	assign done_out = q.done;

	timer_start_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && start_in) |=> (!done_out && q.run && q.cnt != '0))
		else $error("timer not armed after start");

	timer_expire_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(q.done) |-> ($past(q.cnt) == psm_pkg::TMR_MIN && $past(tick_in) && $past(q.run)))
		else $error("timer expired without final tick");

endmodule // psm_timer

`default_nettype wire

// [design/power_sequence_monitor_control.sv]
// Digital control of the power monitor: input sampling, window compare, sequencer,
// four timers, output drivers, trim DAC selection and closed-loop trim.
// Assumes the I2C slave and ADC sequencer run on CLOCK_IN; pins and comparators are async.
`timescale 1ns/1ns
`default_nettype none

module power_sequence_monitor_control (
	input  wire logic                            CLOCK_IN,
	input  wire logic                            RST_N_IN,
	input  wire logic                            CLK_EN_IN,
	input  wire logic [1:0]                      PROFILE_SEL_IN,
	input  wire logic [psm_pkg::N_IN-1:0]        LOGIC_IN,
	input  wire logic [psm_pkg::N_CH-1:0]        CMP_HI_IN,
	input  wire logic [psm_pkg::N_CH-1:0]        CMP_LO_IN,
	input  wire logic [psm_pkg::N_CH-1:0]        CMP_MODE_IN,
	input  wire logic [psm_pkg::N_HV-1:0]        HV_MODE_IN,
	input  wire logic                            PROFILE_SRC_IN,
	input  wire psm_pkg::timer_load_t            TIMER_LOAD_IN,
	input  wire psm_pkg::preset_t                PRESET_IN,
	input  wire psm_pkg::dac_cfg_t               DAC_CFG_IN,
	input  wire psm_pkg::adc_sample_t            ADC_IN,
	input  wire psm_pkg::host_cmd_t              HOST_IN,
	output logic [2*psm_pkg::N_CH-1:0]           CMP_STATUS_OUT,
	output logic [psm_pkg::N_CH-1:0]             CHAN_OK_OUT,
	output logic [psm_pkg::N_IN-1:0]             INPUTS_OUT,
	output logic [psm_pkg::N_OUT-1:0]            LOGIC_OUT_OUT,
	output logic [psm_pkg::N_OUT-1:0]            OD_OE_N_OUT,
	output logic [psm_pkg::N_HV-1:0]             HV_DRIVE_OUT,
	output logic [1:0]                           PROFILE_OUT,
	output psm_pkg::dac_codes_t                  DAC_CODE_OUT,
	output logic [psm_pkg::ADC_W-1:0]            ADC_RESULT_OUT,
	output logic [3:0]                           ADC_CH_OUT,
	output psm_pkg::seq_state_t                  SEQ_STATE_OUT
);

	psm_pkg::main_state_t       q;
	psm_pkg::main_state_t       d;
	logic [psm_pkg::N_TMR-1:0]  tmr_done;

	////////////////////////////////////////////////////////////////////////////////
	// Timers

	for (genvar g = 0; g < psm_pkg::N_TMR; g++) begin : g_tmr
		psm_timer u_tmr (
			.clk_in   (CLOCK_IN),
			.rst_n_in (RST_N_IN),
			.ce_in    (CLK_EN_IN),
			.tick_in  (q.tick),
			.start_in (q.tstart[g]),
			.load_in  (TIMER_LOAD_IN[g]),
			.done_out (tmr_done[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [psm_pkg::N_IN-1:0]  in_raw;
		logic [psm_pkg::N_CH-1:0]  lo;
		logic [psm_pkg::N_CH-1:0]  hi;
		logic [psm_pkg::N_OUT-1:0] eff;
		logic                      grp_ok;
		logic [psm_pkg::DAC_W-1:0] sel;
		in_raw = '0;
		lo     = '0;
		hi     = '0;
		eff    = '0;
		grp_ok = 1'b0;
		sel    = '0;
		d      = q;

		// Three-stage capture; a change is taken once stages two and three agree
		d.s1 = {PROFILE_SEL_IN, LOGIC_IN, CMP_HI_IN, CMP_LO_IN};
		d.s2 = q.s1;
		d.s3 = q.s2;
		// Agreeing stages load the filtered bit, disagreeing stages hold it
		d.f  = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));

		// Free-running 32 us tick shared by all timers
		d.tick = (q.tdiv == psm_pkg::TICK_LAST);
		d.tdiv = d.tick ? '0 : 10'(q.tdiv + 10'h001);

		// Host writes land on the edge after the strobe
		if (HOST_IN.wr) begin
			case (HOST_IN.tgt)
				psm_pkg::TGT_INPUTS: begin
					d.in_ov_val = HOST_IN.data[3:0];
					d.in_ov_en  = HOST_IN.data[7:4];
				end
				psm_pkg::TGT_OUT_VAL: d.out_ov_val = HOST_IN.data;
				psm_pkg::TGT_OUT_EN:  d.out_ov_en  = HOST_IN.data;
				psm_pkg::TGT_DAC:     d.host_dac[HOST_IN.idx] = HOST_IN.data[7:0];
				default: d.in_ov_en = q.in_ov_en;
			endcase
		end

		// Host may override inputs 2..5 only
		in_raw   = q.f[psm_pkg::SY_IN +: psm_pkg::N_IN];
		d.in_eff = {in_raw[5], (q.in_ov_en & q.in_ov_val) | (~q.in_ov_en & in_raw[4:1]),
			in_raw[0]};

		// LO: above lower threshold, HI: above upper threshold
		lo = q.f[psm_pkg::SY_LO +: psm_pkg::N_CH];
		hi = q.f[psm_pkg::SY_HI +: psm_pkg::N_CH];
		d.chan_ok = (CMP_MODE_IN & lo & ~hi) | (~CMP_MODE_IN & lo);

		// Sequencer: each stage powers a group, waits its timer, then checks its channels
		d.tstart = '0;
		grp_ok   = &q.chan_ok[psm_pkg::GRP_CH * q.stage +: psm_pkg::GRP_CH];
		case (q.st)
			psm_pkg::S_IDLE: begin
				d.grp = '0;
				if (q.in_eff[0]) begin
					d.st        = psm_pkg::S_RAMP;
					d.stage     = 2'h0;
					d.grp       = 4'h1;
					d.tstart[0] = 1'b1;
				end
			end
			psm_pkg::S_RAMP: begin
				if (!q.in_eff[0]) begin
					d.st  = psm_pkg::S_IDLE;
					d.grp = '0;
				end else if (tmr_done[q.stage] && !q.tstart[q.stage]) begin
					// Expired timer doubles as the time-out on a stage that never came good
					if (!grp_ok) begin
						d.st  = psm_pkg::S_FAULT;
						d.grp = '0;
					end else if (q.in_eff[3'(q.stage) + 3'h1]) begin
						if (q.stage == 2'h3) begin
							d.st = psm_pkg::S_RUN;
						end else begin
							d.stage                  = 2'(q.stage + 2'h1);
							d.grp[q.stage + 2'h1]    = 1'b1;
							d.tstart[q.stage + 2'h1] = 1'b1;
						end
					end
				end
			end
			psm_pkg::S_RUN: begin
				if (!q.in_eff[0]) begin
					d.st  = psm_pkg::S_IDLE;
					d.grp = '0;
				end else if (!(&q.chan_ok)) begin
					d.st  = psm_pkg::S_FAULT;
					d.grp = '0;
				end
			end
			psm_pkg::S_FAULT: begin
				d.grp = '0;
				if (!q.in_eff[0]) begin
					d.st = psm_pkg::S_IDLE;
				end
			end
			default: begin
				d.st  = psm_pkg::S_IDLE;
				d.grp = '0;
			end
		endcase

		for (int g = 0; g < psm_pkg::N_TMR; g++) begin
			d.seq_out[psm_pkg::GRP_W * g +: psm_pkg::GRP_W] = {psm_pkg::GRP_W{q.grp[g]}};
		end

		// Open drain: a low level pulls the pin; gate-driver mode releases the pin instead
		eff    = (q.out_ov_en & q.out_ov_val) | (~q.out_ov_en & q.seq_out);
		d.oe_n = eff;
		d.oe_n[psm_pkg::N_HV-1:0] = eff[psm_pkg::N_HV-1:0] | HV_MODE_IN;
		d.hv   = eff[psm_pkg::N_HV-1:0] & HV_MODE_IN;

		d.prof = PROFILE_SRC_IN ? {q.in_eff[5], q.st == psm_pkg::S_RUN}
			: q.f[psm_pkg::SY_PS +: 2];

		if (ADC_IN.valid) begin
			d.adc    = ADC_IN.data;
			d.adc_ch = ADC_IN.ch;
		end

		// One code step per matching sample keeps the loop slow and stable
		for (int i = 0; i < psm_pkg::N_DAC; i++) begin
			sel = DAC_CFG_IN.src_host[i] ? q.host_dac[i] : PRESET_IN[q.prof][i];
			if (!DAC_CFG_IN.closed_loop[i]) begin
				d.trim[i] = sel;
			end else if (ADC_IN.valid && ADC_IN.ch == 4'(i)) begin
				if (ADC_IN.data < DAC_CFG_IN.target[i] && q.trim[i] != psm_pkg::DAC_TOP) begin
					d.trim[i] = 8'(q.trim[i] + 8'h01);
				end else if (ADC_IN.data > DAC_CFG_IN.target[i]
					&& q.trim[i] != psm_pkg::DAC_BOT) begin
					d.trim[i] = 8'(q.trim[i] - 8'h01);
				end
			end
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			q <= psm_pkg::MAIN_RST;
		end else if (CLK_EN_IN) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign CMP_STATUS_OUT = q.f[psm_pkg::SY_HI + psm_pkg::N_CH - 1 : psm_pkg::SY_LO];
	assign CHAN_OK_OUT    = q.chan_ok;
	assign INPUTS_OUT     = q.in_eff;
	assign LOGIC_OUT_OUT  = q.seq_out;
	assign OD_OE_N_OUT    = q.oe_n;
	assign HV_DRIVE_OUT   = q.hv;
	assign PROFILE_OUT    = q.prof;
	assign DAC_CODE_OUT   = q.trim;
	assign ADC_RESULT_OUT = q.adc;
	assign ADC_CH_OUT     = q.adc_ch;
	assign SEQ_STATE_OUT  = q.st;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);

	input_sync_a: assert property (
		(CLK_EN_IN && q.s2 == q.s3) |=> (q.f == $past(q.s2)))
		else $error("filtered input did not follow agreeing stages");

	profile_pin_a: assert property (
		(CLK_EN_IN && !PROFILE_SRC_IN) |=> (PROFILE_OUT == $past(q.f[psm_pkg::SY_PS +: 2])))
		else $error("profile not taken from sampled pins");

	window_mode_a: assert property (
		(CLK_EN_IN && CMP_MODE_IN[0] && q.f[psm_pkg::SY_HI]) |=> !CHAN_OK_OUT[0])
		else $error("window compare passed above upper threshold");

	host_input_a: assert property (
		(CLK_EN_IN && HOST_IN.wr && HOST_IN.tgt == psm_pkg::TGT_INPUTS && HOST_IN.data[4])
		##1 CLK_EN_IN |=> (INPUTS_OUT[1] == $past(HOST_IN.data[0], 2)))
		else $error("host input override not applied");

	fault_off_a: assert property (
		(q.st == psm_pkg::S_FAULT) ##1 (CLK_EN_IN && q.st == psm_pkg::S_FAULT)
		|=> (LOGIC_OUT_OUT == '0))
		else $error("outputs active in fault state");

	od_drive_a: assert property (
		(CLK_EN_IN && !HV_MODE_IN[0]) |=> (!HV_DRIVE_OUT[0]
			&& OD_OE_N_OUT[0] == $past((q.out_ov_en[0] & q.out_ov_val[0])
			| (~q.out_ov_en[0] & q.seq_out[0]))))
		else $error("open-drain level wrong");

	adc_latch_a: assert property (
		(CLK_EN_IN && ADC_IN.valid) |=> (ADC_RESULT_OUT == $past(ADC_IN.data)))
		else $error("converter result not latched");

	trim_step_a: assert property (
		(CLK_EN_IN && DAC_CFG_IN.closed_loop[0] && ADC_IN.valid && ADC_IN.ch == 4'h0
			&& ADC_IN.data < DAC_CFG_IN.target[0] && q.trim[0] != psm_pkg::DAC_TOP)
		|=> (DAC_CODE_OUT[0] == 8'($past(q.trim[0]) + 8'h01)))
		else $error("closed-loop trim did not step up");

endmodule // power_sequence_monitor_control

`default_nettype wire

// [tb/psm_host_model.sv]
// Host microcontroller model: issues completed register writes on the host port.
// Assumes the device samples HOST_IN on rising edges; the model changes it at falling edges.
`timescale 1ns/1ns
`default_nettype none

module psm_host_model (
	input  wire logic              clk_in,
	output var psm_pkg::host_cmd_t host_out
);
	initial begin
		host_out = '0;
	end

	// Payload is inverted between writes so stale data never looks current
	task automatic write(input logic [1:0] tgt, input logic [2:0] idx, input logic [19:0] data);
		@(negedge clk_in);
		host_out = '{wr: 1'b1, tgt: tgt, idx: idx, data: data};
		@(negedge clk_in);
		host_out.wr = 1'b0;
		host_out.data = ~data;
	endtask
endmodule // psm_host_model

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the power sequence monitor control block.
// Assumes a 20 MHz clock; inputs change at falling edges, checks run at falling edges.
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic                    clk = 0, rst_n = 0, clk_en = 1, prof_src = 0;
	logic [1:0]              prof_sel = 0, prof_o;
	logic [5:0]              pins = 0, inputs_o, prev = 0;
	logic [11:0]             hi = 0, lo = 0, mode = 0, chan_ok;
	logic [3:0]              hv_mode = 0, hv_drv, adc_ch;
	logic [23:0]             cmp_st;
	logic [19:0]             lout, oe_n, val, en;
	logic [9:0]              adc_res, last;
	logic [7:0]              ov;
	psm_pkg::timer_load_t    tload = '{default: 16'h0001};
	psm_pkg::preset_t        preset;
	psm_pkg::dac_cfg_t       dcfg = '0;
	psm_pkg::adc_sample_t    adc = '0;
	psm_pkg::host_cmd_t      host;
	psm_pkg::dac_codes_t     dac_o, hcode;
	psm_pkg::seq_state_t     st;
	integer                  seed = 32'ha0790c87;
	int                      errors = 0, num_checks = 0, n;

	power_sequence_monitor_control u_power_sequence_monitor_control (
		.CLOCK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(clk_en), .PROFILE_SEL_IN(prof_sel),
		.LOGIC_IN(pins), .CMP_HI_IN(hi), .CMP_LO_IN(lo), .CMP_MODE_IN(mode),
		.HV_MODE_IN(hv_mode), .PROFILE_SRC_IN(prof_src), .TIMER_LOAD_IN(tload),
		.PRESET_IN(preset), .DAC_CFG_IN(dcfg), .ADC_IN(adc), .HOST_IN(host),
		.CMP_STATUS_OUT(cmp_st), .CHAN_OK_OUT(chan_ok), .INPUTS_OUT(inputs_o),
		.LOGIC_OUT_OUT(lout), .OD_OE_N_OUT(oe_n), .HV_DRIVE_OUT(hv_drv),
		.PROFILE_OUT(prof_o), .DAC_CODE_OUT(dac_o), .ADC_RESULT_OUT(adc_res),
		.ADC_CH_OUT(adc_ch), .SEQ_STATE_OUT(st)
	);

	psm_host_model u_psm_host_model (.clk_in(clk), .host_out(host));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #25 clk = ~clk;
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [11:0] ok_of(input logic [11:0] h, l, m);
		return (m & l & ~h) | (~m & l);
	endfunction

	function automatic logic [5:0] eff_of(input logic [5:0] p, input logic [7:0] o);
		return {p[5], (o[7:4] & o[3:0]) | (~o[7:4] & p[4:1]), p[0]};
	endfunction

	function automatic psm_pkg::dac_codes_t dac_of(input logic [1:0] p);
		for (int i = 0; i < 8; i++)
			dac_of[i] = dcfg.src_host[i] ? hcode[i] : preset[p][i];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int p = 0; p < 4; p++)
			for (int d = 0; d < 8; d++)
				preset[p][d] = 8'($random(seed));
		hcode = '0;
		cyc(10);
		chk("reset state", psm_pkg::S_IDLE, st);
		chk("reset oe", 20'h00000, oe_n);
		cyc(2);
		rst_n = 1;
		// Input1 stays low so the sequencer idles
		for (int t = 0; t < 8; t++) begin
			prev = pins;
			pins = 6'($random(seed)) & 6'h3E;
			{hi, lo, mode} = 36'($random(seed));
			prof_sel = 2'($random(seed));
			cyc(1);
			// One edge after a pin change the old level must still show
			chk("early input", eff_of(prev, 8'h00), inputs_o);
			cyc(6);
			chk("inputs", eff_of(pins, 8'h00), inputs_o);
			chk("status", {hi, lo}, cmp_st);
			chk("chan ok", ok_of(hi, lo, mode), chan_ok);
			chk("profile", prof_sel, prof_o);
			chk("dac preset", dac_of(prof_sel), dac_o);
		end
		$display("test pins done");
		ov = 8'($random(seed));
		u_psm_host_model.write(psm_pkg::TGT_INPUTS, 3'h0, {12'h000, ov});
		cyc(2);
		chk("input override", eff_of(pins, ov), inputs_o);
		val = 20'($random(seed));
		en = 20'($random(seed));
		u_psm_host_model.write(psm_pkg::TGT_OUT_VAL, 3'h0, val);
		u_psm_host_model.write(psm_pkg::TGT_OUT_EN, 3'h0, en);
		cyc(2);
		chk("od enable", val & en, oe_n);
		hv_mode = 4'hF;
		cyc(3);
		chk("gate drive", 4'(val & en), hv_drv);
		chk("od upper", 16'((val & en) >> 4), 16'(oe_n >> 4));
		chk("od released", 4'hF, oe_n[3:0]);
		dcfg.src_host = 8'($random(seed));
		for (int i = 0; i < 8; i++) begin
			hcode[i] = 8'($random(seed));
			u_psm_host_model.write(psm_pkg::TGT_DAC, 3'(i), {12'h000, hcode[i]});
		end
		cyc(2);
		chk("dac host", dac_of(prof_sel), dac_o);
		pins = 6'h20;
		prof_src = 1;
		cyc(7);
		chk("logic profile", 2'b10, prof_o);
		chk("dac profile", dac_of(2'b10), dac_o);
		$display("test host done");
		dcfg = '0;
		dcfg.closed_loop = 8'h01;
		dcfg.target[0] = 10'h200;
		for (int k = 0; k < 600; k++) begin
			last = (k < 300) ? {1'b0, 9'($random(seed))} : (10'h300 | 10'($random(seed)));
			adc = '{valid: 1'b1, ch: 4'h0, data: last};
			cyc(1);
			if (k == 299)
				chk("trim up", 8'hFF, dac_o[0]);
		end
		adc.valid = 0;
		chk("trim down", 8'h00, dac_o[0]);
		chk("adc data", last, adc_res);
		// Below target on another channel: trim 0 must not step up
		adc = '{valid: 1'b1, ch: 4'h9, data: 10'h000};
		cyc(1);
		adc.valid = 0;
		chk("adc chan", 4'h9, adc_ch);
		cyc(1);
		chk("trim hold", 8'h00, dac_o[0]);
		$display("test trim done");
		dcfg = '0;
		clk_en = 0;
		pins = 6'h1E;
		cyc(8);
		chk("frozen", eff_of(6'h20, ov), inputs_o);
		clk_en = 1;
		u_psm_host_model.write(psm_pkg::TGT_INPUTS, 3'h0, 20'h00000);
		{hi, mode} = '0;
		lo = 12'hFFF;
		tload[0] = 16'h0003;
		pins = 6'h3F;
		n = 0;
		while (st !== psm_pkg::S_RAMP && n < 20) begin
			cyc(1);
			n++;
		end
		chk("ramp", psm_pkg::S_RAMP, st);
		n = 0;
		while (lout[5] !== 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk("stage time", 1, n >= 1270 && n <= 1940);
		n = 0;
		while (st !== psm_pkg::S_RUN && n < 4000) begin
			cyc(1);
			n++;
		end
		cyc(2);
		chk("run", psm_pkg::S_RUN, st);
		chk("all on", 20'hFFFFF, lout);
		lo[0] = 0;
		cyc(8);
		chk("fault", psm_pkg::S_FAULT, st);
		chk("all off", 20'h00000, lout);
		pins[0] = 0;
		cyc(8);
		chk("idle", psm_pkg::S_IDLE, st);
		$display("test sequencer done");
		wrap_up();
	end

	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		wrap_up();
	end
endmodule // tb

`default_nettype wire
